// File: rtl/dual_serial_port.sv
/*
  Dual asynchronous serial controller, device side of a byte-wide host bus.
  Assumes bus, serial clock and modem pins are asynchronous, srst and chain_enable_in synchronous; bus strobes last many ref_clk cycles.
*/
`timescale 1ns/1ps
module dual_serial_port (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire dual_serial_pkg::host_bus_s bus_in,
  output logic [7:0]                      data_out,
  output logic                            data_oe,
  input  wire logic                       chain_enable_in,
  output logic                            chain_enable_out,
  output logic                            int_out_n,
  output logic                            int_oe,
  input  wire logic                       chan_a_transmit_clock,
  input  wire logic                       chan_a_receive_clock,
  input  wire logic                       chan_b_shared_clock,
  input  wire dual_serial_pkg::modem_in_s modem_a,
  input  wire dual_serial_pkg::modem_in_s modem_b,
  output logic [1:0]                      txd,
  output logic [1:0]                      terminal_ready_n,
  output logic [1:0]                      send_request_n
);
  localparam int NPIN = 14 + 3 + 8;
  // ==========================================================
  // pin synchronisers: a change counts once stages two and three agree
  logic [NPIN-1:0] raw, s1, s2, s3, flt;
  assign raw = {bus_in, chan_a_transmit_clock, chan_a_receive_clock, chan_b_shared_clock,
                modem_a, modem_b};
  genvar g;
  for (g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      s1[g] <= raw[g];
      s2[g] <= s1[g];
      s3[g] <= s2[g];
      if (srst) flt[g] <= 1'b1;
      else if (s2[g] == s3[g]) flt[g] <= s3[g];
    end
  end
  dual_serial_pkg::host_bus_s bus;
  dual_serial_pkg::modem_in_s mdm [2];
  logic [1:0] txc, rxc, txc_d, rxc_d, tx_tick, rx_tick;
  assign bus = flt[24:11];
  assign mdm[0] = flt[7:4];
  assign mdm[1] = flt[3:0];
  assign txc = {flt[8], flt[10]};
  assign rxc = {flt[8], flt[9]};
  always_ff @(posedge ref_clk) begin
    txc_d <= txc;
    rxc_d <= rxc;
  end
  assign tx_tick = txc & ~txc_d;
  assign rx_tick = rxc & ~rxc_d;
  // ==========================================================
  // bus cycle decode; each action is taken once at the start of a cycle
  logic sel, ack, sel_d, ack_d, acc_go, ack_go, rd_go, wr_go;
  assign sel = !bus.ce_n && !bus.io_request_n && bus.fetch_cycle_n;
  assign ack = !bus.fetch_cycle_n && !bus.io_request_n;
  always_ff @(posedge ref_clk) begin
    sel_d <= srst ? 1'b0 : sel;
    ack_d <= srst ? 1'b0 : ack;
  end
  assign acc_go = sel && !sel_d;
  assign ack_go = ack && !ack_d;
  assign rd_go  = acc_go && !bus.rd_n;
  assign wr_go  = acc_go && bus.rd_n;
  // ==========================================================
  // per channel state
  logic [6:0] mode [2];
  logic [3:0] vec_base;
  logic [3:0] pend [2];
  logic [7:0] fifo [2][dual_serial_pkg::FIFO_DEPTH];
  logic [1:0] fcnt [2];
  logic [7:0] hold [2];
  logic [1:0] hold_full, brk, tx_load;
  logic [7:0] status [2];
  logic [1:0] ctl_wr, dat_wr, ctl_rd, dat_rd;
  for (g = 0; g < 2; g++) begin : g_chan
    logic [10:0] tsh;
    logic [3:0]  tcnt, rcnt;
    logic [9:0]  rsh;
    logic [2:0]  modem_d;
    logic        perr, ferr, push;
    logic        ch_hit;
    assign ch_hit = (bus.ba_sel == 1'(g));
    assign ctl_wr[g] = wr_go && ch_hit && bus.cd_sel;
    assign dat_wr[g] = wr_go && ch_hit && !bus.cd_sel;
    assign ctl_rd[g] = rd_go && ch_hit && bus.cd_sel;
    assign dat_rd[g] = rd_go && ch_hit && !bus.cd_sel;
    // configuration bytes
    always_ff @(posedge ref_clk) begin
      if (srst) mode[g] <= dual_serial_pkg::MODE_RESET;
      else if (ctl_wr[g] && bus.data[dual_serial_pkg::MODE_FLAG]) mode[g] <= bus.data[6:0];
    end
    assign terminal_ready_n[g] = !mode[g][dual_serial_pkg::MODE_DTR];
    assign send_request_n[g]   = !mode[g][dual_serial_pkg::MODE_RTS];
    // transmitter: holding buffer then shifter; auto enable waits for clear to send
    assign tx_load[g] = tx_tick[g] && tcnt == 4'h0 && hold_full[g]
                        && mode[g][dual_serial_pkg::MODE_TX_EN]
                        && !(mode[g][dual_serial_pkg::MODE_AUTO] && mdm[g].cts_n);
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        hold_full[g] <= 1'b0;
        hold[g]      <= 8'h00;
        tsh          <= '1;
        tcnt         <= 4'h0;
      end else begin
        if (dat_wr[g]) begin
          hold[g]      <= bus.data;
          hold_full[g] <= 1'b1;
        end else if (tx_load[g]) hold_full[g] <= 1'b0;
        if (tx_load[g]) begin
          tsh  <= {1'b1, mode[g][dual_serial_pkg::MODE_PARITY] ? ^hold[g] : 1'b1,
                   hold[g], 1'b0};
          tcnt <= 4'(dual_serial_pkg::FRAME_BITS);
        end else if (tx_tick[g] && tcnt != 4'h0) begin
          tsh  <= {1'b1, tsh[10:1]};
          tcnt <= tcnt - 4'h1;
        end
      end
    end
    assign txd[g] = (tcnt == 4'h0) ? 1'b1 : tsh[0];
    // receiver: x1 clock, frame gathered after the start bit
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        rcnt <= 4'h0;
        rsh  <= 10'h000;
      end else if (rx_tick[g]) begin
        if (rcnt != 4'h0) begin
          rsh  <= {mdm[g].rxd, rsh[9:1]};
          rcnt <= rcnt - 4'h1;
        end else if (!mdm[g].rxd
                     && !(mode[g][dual_serial_pkg::MODE_AUTO] && mdm[g].dcd_n)) begin
          rcnt <= 4'(dual_serial_pkg::RX_BITS);
        end
      end
    end
    assign push = rx_tick[g] && rcnt == 4'h1;
    assign ferr = !mdm[g].rxd || (!mode[g][dual_serial_pkg::MODE_PARITY] && !rsh[9]);
    assign perr = mode[g][dual_serial_pkg::MODE_PARITY] && (rsh[9] != ^rsh[8:1]);
    // three-entry receive fifo; the head sits in entry zero
    always_ff @(posedge ref_clk) begin
      if (srst) fcnt[g] <= 2'h0;
      else begin
        if (dat_rd[g] && fcnt[g] != 2'h0) begin
          fifo[g][0] <= fifo[g][1];
          fifo[g][1] <= fifo[g][2];
        end
        if (push && fcnt[g] != 2'(dual_serial_pkg::FIFO_DEPTH))
          fifo[g][2'(fcnt[g] - 2'(dat_rd[g] && fcnt[g] != 2'h0))] <= rsh[8:1];
        fcnt[g] <= 2'(fcnt[g] + 2'(push && fcnt[g] != 2'(dual_serial_pkg::FIFO_DEPTH))
                   - 2'(dat_rd[g] && fcnt[g] != 2'h0));
      end
    end
    // interrupt sources; a setting event beats a clear in the same cycle
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        pend[g]  <= 4'h0;
        brk[g]   <= 1'b0;
        modem_d  <= 3'h7;
      end else begin
        modem_d <= {mdm[g].ri_n, mdm[g].cts_n, mdm[g].dcd_n};
        if (push && (ferr || perr || fcnt[g] == 2'(dual_serial_pkg::FIFO_DEPTH)))
          pend[g][dual_serial_pkg::SRC_SPECIAL] <= 1'b1;
        else if (ctl_wr[g] && bus.data[7:6] == 2'b00
                 && bus.data[2:0] == dual_serial_pkg::CMD_ERR_RESET)
          pend[g][dual_serial_pkg::SRC_SPECIAL] <= 1'b0;
        if (push) pend[g][dual_serial_pkg::SRC_RX] <= 1'b1;
        else if (dat_rd[g] && fcnt[g] <= 2'h1) pend[g][dual_serial_pkg::SRC_RX] <= 1'b0;
        if (tx_load[g]) pend[g][dual_serial_pkg::SRC_TX] <= 1'b1;
        else if (dat_wr[g] || (ctl_wr[g] && bus.data[7:6] == 2'b00
                 && bus.data[2:0] == dual_serial_pkg::CMD_RESET_TX))
          pend[g][dual_serial_pkg::SRC_TX] <= 1'b0;
        if (push && ferr && rsh[8:1] == 8'h00) brk[g] <= 1'b1;
        else if (brk[g] && mdm[g].rxd) brk[g] <= 1'b0;
        if (modem_d != {mdm[g].ri_n, mdm[g].cts_n, mdm[g].dcd_n}
            || (push && ferr && rsh[8:1] == 8'h00 && !brk[g]) || (brk[g] && mdm[g].rxd))
          pend[g][dual_serial_pkg::SRC_EXT] <= 1'b1;
        else if (ctl_wr[g] && bus.data[7:6] == 2'b00
                 && bus.data[2:0] == dual_serial_pkg::CMD_RESET_EXT)
          pend[g][dual_serial_pkg::SRC_EXT] <= 1'b0;
      end
    end
    assign status[g] = {brk[g], !mdm[g].cts_n, !mdm[g].dcd_n, !mdm[g].ri_n,
                        !hold_full[g], pend[g][dual_serial_pkg::SRC_SPECIAL], 1'b0,
                        fcnt[g] != 2'h0};
    a_tx_empty_raise: assert property (@(posedge ref_clk) disable iff (srst)
      tx_load[g] |=> pend[g][dual_serial_pkg::SRC_TX]) else $error("tx empty not raised");
    a_special_held: assert property (@(posedge ref_clk) disable iff (srst)
      pend[g][0] && !ctl_wr[g] |=> pend[g][0]) else $error("special dropped early");
    a_fifo_entry: assert property (@(posedge ref_clk) disable iff (srst)
      push && fcnt[g] != 2'(dual_serial_pkg::FIFO_DEPTH) && !dat_rd[g]
      |=> fcnt[g] == 2'($past(fcnt[g]) + 2'h1) && pend[g][dual_serial_pkg::SRC_RX])
      else $error("receive entry not counted");
    a_dtr_follow: assert property (@(posedge ref_clk) disable iff (srst)
      ctl_wr[g] && bus.data[7] |=> terminal_ready_n[g] == !$past(bus.data[0]))
      else $error("terminal ready not following software");
  end
  always_ff @(posedge ref_clk) begin
    if (srst) vec_base <= dual_serial_pkg::VEC_RESET;
    else if (ctl_wr[1] && bus.data[7:6] == 2'b01) vec_base <= bus.data[3:0];
  end
  // ==========================================================
  // fixed priority across the eight sources, channel A first
  logic [7:0] req;
  logic [2:0] top;
  logic       any_req, in_svc;
  logic [2:0] svc_idx;
  logic [7:0] vector;
  assign req = {pend[1] & {4{mode[1][dual_serial_pkg::MODE_IRQ_EN]}},
                pend[0] & {4{mode[0][dual_serial_pkg::MODE_IRQ_EN]}}};
  always_comb begin
    top = 3'h0;
    for (int i = 7; i >= 0; i--) if (req[i]) top = 3'(i);
  end
  assign any_req = |req;
  // status may select the vector; only bits 3:1 are replaced
  assign vector = mode[1][dual_serial_pkg::MODE_VEC_STATUS]
                  ? {vec_base, top, 1'b0} : {vec_base, 4'h0};
  // service ends when the acknowledged source is cleared by software
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      in_svc  <= 1'b0;
      svc_idx <= 3'h0;
    end else if (ack_go && chain_enable_in && any_req) begin
      in_svc  <= 1'b1;
      svc_idx <= top;
    end else if (in_svc && !req[svc_idx]) in_svc <= 1'b0;
  end
  assign int_out_n        = 1'b0;
  assign int_oe           = any_req && chain_enable_in && !in_svc;
  assign chain_enable_out = chain_enable_in && !any_req && !in_svc;
  // ==========================================================
  // data bus drive, held for the whole read or acknowledge cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_oe  <= 1'b0;
      data_out <= 8'h00;
    end else begin
      if (rd_go) begin
        data_oe  <= 1'b1;
        data_out <= bus.cd_sel ? status[bus.ba_sel] : fifo[bus.ba_sel][0];
      end else if (ack_go && chain_enable_in && any_req) begin
        data_oe  <= 1'b1;
        data_out <= vector;
      end else if (!sel && !ack) data_oe <= 1'b0;
    end
  end
  a_read_drive: assert property (@(posedge ref_clk) disable iff (srst)
    rd_go |=> data_oe ##1 (data_oe || !sel)) else $error("read not driven");
  a_write_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    wr_go && !data_oe |=> !data_oe) else $error("write cycle drove bus");
  a_ack_vector: assert property (@(posedge ref_clk) disable iff (srst)
    ack_go && chain_enable_in && any_req |=> data_oe && data_out == $past(vector))
    else $error("acknowledge vector wrong");
  a_chain_block: assert property (@(posedge ref_clk) disable iff (srst)
    ack_go && chain_enable_in && any_req |=> in_svc && !int_oe && !chain_enable_out)
    else $error("chain passed during service");
endmodule : dual_serial_port

// File: rtl/dual_serial_pkg.sv
/*
  Constants and carrier types for the dual asynchronous serial host port.
  Assumes a single 20 MHz clock and pins sampled through synchronisers.
*/
package dual_serial_pkg;
  // ==========================================================
  // control-port write byte layout
  localparam int MODE_FLAG       = 7;  // 1: mode byte, 0: command or vector byte
  localparam int VEC_FLAG        = 6;  // with MODE_FLAG low: vector base write
  localparam int MODE_DTR        = 0;
  localparam int MODE_RTS        = 1;
  localparam int MODE_AUTO       = 2;
  localparam int MODE_IRQ_EN     = 3;
  localparam int MODE_VEC_STATUS = 4;
  localparam int MODE_PARITY     = 5;
  localparam int MODE_TX_EN      = 6;
  localparam logic [6:0] MODE_RESET = 7'h00;
  localparam logic [3:0] VEC_RESET  = 4'h0;
  // ==========================================================
  // commands, in bits 2:0 of a command byte
  localparam logic [2:0] CMD_RESET_EXT = 3'h2;
  localparam logic [2:0] CMD_RESET_TX  = 3'h5;
  localparam logic [2:0] CMD_ERR_RESET = 3'h6;
  // ==========================================================
  // frame and buffer sizes, interrupt source bits
  localparam int FIFO_DEPTH  = 3;
  localparam int FRAME_BITS  = 11;  // start, 8 data, parity or stop, stop
  localparam int RX_BITS     = 10;  // bits gathered after the start bit
  localparam int SRC_SPECIAL = 0;
  localparam int SRC_RX      = 1;
  localparam int SRC_TX      = 2;
  localparam int SRC_EXT     = 3;
  // ==========================================================
  typedef struct packed {
    logic       ce_n;
    logic       io_request_n;
    logic       rd_n;
    logic       fetch_cycle_n;
    logic       cd_sel;
    logic       ba_sel;
    logic [7:0] data;
  } host_bus_s;
  typedef struct packed {
    logic ri_n;
    logic dcd_n;
    logic cts_n;
    logic rxd;
  } modem_in_s;
endpackage : dual_serial_pkg

// File: dv/host_cpu_model.sv
/*
  Processor-side bus model for the dual serial port: io cycles and acknowledge.
  Assumes a free-running ref_clk; every cycle starts and ends 5 ns after a rising edge.
*/
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic                  ref_clk,
  input  wire logic [7:0]            data_out,
  input  wire logic                  data_oe,
  output dual_serial_pkg::host_bus_s bus
);
  initial begin
    bus = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'hff};
  end
  // ==========================================================
  // one bus cycle
  // selects and data settle two edges ahead of the strobes so the filter never sees a mix
  task automatic cycle(input logic sel, input logic rd, input logic ack, input logic cd,
                       input logic ba, input logic [7:0] wdata,
                       output logic [7:0] rdata, output logic answered);
    int n;
    answered = 1'b0;
    rdata = 8'h00;
    @(posedge ref_clk);
    #5;
    bus.cd_sel = cd;
    bus.ba_sel = ba;
    bus.data = rd ? ~bus.data : wdata;
    repeat (2) @(posedge ref_clk);
    #5;
    bus.ce_n = ~sel;
    bus.io_request_n = 1'b0;
    bus.rd_n = ~rd;
    bus.fetch_cycle_n = ~ack;
    for (n = 0; n < 24 && !answered; n++) begin
      @(posedge ref_clk);
      #1;
      if (data_oe === 1'b1) begin
        answered = 1'b1;
        rdata = data_out;
      end
    end
    @(posedge ref_clk);
    #5;
    bus = '{1'b1, 1'b1, 1'b1, 1'b1, cd, ba, ~bus.data};
    for (n = 0; n < 24 && data_oe !== 1'b0; n++) @(posedge ref_clk);
    repeat (6) @(posedge ref_clk);
    #5;
  endtask : cycle
endmodule : host_cpu_model

// File: dv/dual_serial_port_tb.sv
/*
  Self-checking bench for dual_serial_port: reset, modem lines, select, serial, interrupts.
  Assumes the design package and host_cpu_model are compiled before this file.
*/
`timescale 1ns/1ps
module dual_serial_port_tb;
  localparam logic [3:0] VEC_BASE = 4'h9;
  localparam logic [7:0] RX_BYTE  = 8'h3c;
  logic                       ref_clk, srst, chain_enable_in, chain_enable_out;
  logic                       int_out_n, int_oe, data_oe, answered;
  logic                       chan_a_transmit_clock, chan_a_receive_clock, chan_b_shared_clock;
  logic [7:0]                 data_out, got;
  logic [1:0]                 txd, terminal_ready_n, send_request_n;
  logic [13:0]                line;
  dual_serial_pkg::host_bus_s bus_in;
  dual_serial_pkg::modem_in_s modem_a, modem_b;
  int                         fails, checks_done;

  host_cpu_model cpu_u (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .bus(bus_in));
  dual_serial_port dut_u (
    .ref_clk(ref_clk), .srst(srst), .bus_in(bus_in), .data_out(data_out), .data_oe(data_oe),
    .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
    .int_out_n(int_out_n), .int_oe(int_oe), .chan_a_transmit_clock(chan_a_transmit_clock),
    .chan_a_receive_clock(chan_a_receive_clock), .chan_b_shared_clock(chan_b_shared_clock),
    .modem_a(modem_a), .modem_b(modem_b), .txd(txd), .terminal_ready_n(terminal_ready_n),
    .send_request_n(send_request_n)
  );
  always #25 ref_clk = ~ref_clk;
  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic wr(input logic cd, input logic ba, input logic [7:0] b);
    cpu_u.cycle(1'b1, 1'b0, 1'b0, cd, ba, b, got, answered);
    check({7'h00, answered}, 8'h00);
  endtask : wr
  task automatic rd(input logic sel, input logic ack, input logic cd, input logic ba);
    cpu_u.cycle(sel, ~ack, ack, cd, ba, 8'h00, got, answered);
    check({7'h00, data_oe}, 8'h00);
  endtask : rd
  // bit clocks stand still between ticks, as a rate generator gated per frame would
  task automatic tick(input logic [1:0] pin);
    repeat (4) @(posedge ref_clk);
    #5;
    case (pin)
      2'h0: chan_a_transmit_clock = 1'b1;
      2'h1: chan_b_shared_clock = 1'b1;
      default: chan_a_receive_clock = 1'b1;
    endcase
    repeat (8) @(posedge ref_clk);
    #5;
    chan_b_shared_clock = 1'b0;
    chan_a_transmit_clock = 1'b0;
    chan_a_receive_clock = 1'b0;
    repeat (8) @(posedge ref_clk);
    #5;
  endtask : tick
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================
  // scenarios
  task automatic test_reset;
    @(posedge ref_clk);
    #5;
    chain_enable_in = 1'b0;
    #1;
    check({7'h00, chain_enable_out}, 8'h00);
    @(posedge ref_clk);
    #5;
    chain_enable_in = 1'b1;
    #1;
    check({7'h00, chain_enable_out}, 8'h01);
    check({data_oe, int_oe, txd, terminal_ready_n, send_request_n}, 8'h3f);
    $display("test reset done");
  endtask : test_reset
  task automatic test_modem;
    wr(1'b1, 1'b0, 8'h83);
    check({4'h0, terminal_ready_n, send_request_n}, 8'h0a);
    modem_a = '{1'b0, 1'b1, 1'b0, 1'b1};
    rd(1'b1, 1'b0, 1'b1, 1'b0);
    check({7'h00, answered}, 8'h01);
    check(got & 8'h70, 8'h50);
    modem_a = '{1'b1, 1'b1, 1'b1, 1'b1};
    wr(1'b1, 1'b0, 8'h80);
    check({4'h0, terminal_ready_n, send_request_n}, 8'h0f);
    rd(1'b0, 1'b0, 1'b0, 1'b0);
    check({7'h00, answered}, 8'h00);
    $display("test modem and select done");
  endtask : test_modem
  task automatic test_serial;
    int s;
    logic [11:0] frame;
    frame = {3'b111, RX_BYTE, 1'b0};
    wr(1'b1, 1'b0, 8'hc8);
    wr(1'b1, 1'b1, 8'h98);
    wr(1'b1, 1'b1, {4'h4, VEC_BASE});
    wr(1'b1, 1'b0, 8'h02);
    wr(1'b1, 1'b1, 8'h02);
    check({6'h00, int_out_n, int_oe}, 8'h00);
    wr(1'b0, 1'b0, 8'ha5);
    line[0] = txd[0];
    for (int i = 1; i < 14; i++) begin
      tick(2'h0);
      line[i] = txd[0];
    end
    s = 0;
    while (s < 3 && line[s] !== 1'b0) s++;
    check(line[s + 1 +: 8], 8'ha5);
    check({5'h00, line[s + 10], line[s + 9], line[s]}, 8'h06);
    check({5'h00, int_out_n, int_oe, chain_enable_out}, 8'h02);
    for (int i = 0; i < 12; i++) begin
      modem_b.rxd = frame[i];
      tick(2'h1);
    end
    rd(1'b0, 1'b1, 1'b0, 1'b0);
    check(got, {VEC_BASE, 3'd2, 1'b0});
    check({7'h00, int_oe}, 8'h00);
    wr(1'b1, 1'b0, 8'h05);
    check({7'h00, int_oe}, 8'h01);
    rd(1'b0, 1'b1, 1'b0, 1'b0);
    check(got, {VEC_BASE, 3'd5, 1'b0});
    rd(1'b1, 1'b0, 1'b0, 1'b1);
    check(got, RX_BYTE);
    check({7'h00, int_oe}, 8'h00);
    $display("test serial and interrupts done");
  endtask : test_serial
  // parity on channel A through its own receive clock; the ninth bit is sent high,
  // against the parity of the byte, so special must outrank receive available
  task automatic test_errors;
    logic [11:0] frame;
    frame = {3'b111, RX_BYTE, 1'b0};
    wr(1'b1, 1'b0, 8'ha8);
    for (int i = 0; i < 12; i++) begin
      modem_a.rxd = frame[i];
      tick(2'h2);
    end
    rd(1'b0, 1'b1, 1'b0, 1'b0);
    check(got, {VEC_BASE, 3'h0, 1'b0});
    rd(1'b1, 1'b0, 1'b1, 1'b0);
    check(got & 8'h05, 8'h05);
    wr(1'b1, 1'b0, 8'h06);
    rd(1'b1, 1'b0, 1'b1, 1'b0);
    check(got & 8'h05, 8'h01);
    check({7'h00, int_oe}, 8'h01);
    rd(1'b1, 1'b0, 1'b0, 1'b0);
    check(got, RX_BYTE);
    check({7'h00, int_oe}, 8'h00);
    $display("test receive errors done");
  endtask : test_errors
  // reset in mid run must drop mode bits and a loaded holding buffer
  task automatic test_mid_reset;
    wr(1'b1, 1'b1, 8'h83);
    wr(1'b0, 1'b1, 8'h5a);
    check({4'h0, terminal_ready_n, send_request_n}, 8'h05);
    rd(1'b1, 1'b0, 1'b1, 1'b1);
    check(got & 8'h08, 8'h00);
    srst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #5;
    srst = 1'b0;
    check({data_oe, int_oe, txd, terminal_ready_n, send_request_n}, 8'h3f);
    repeat (4) @(posedge ref_clk);
    rd(1'b1, 1'b0, 1'b1, 1'b1);
    check(got, 8'h08);
    $display("test mid reset done");
  endtask : test_mid_reset
  // ==========================================================
  // main sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    chain_enable_in = 1'b1;
    chan_a_transmit_clock = 1'b0;
    chan_a_receive_clock = 1'b0;
    chan_b_shared_clock = 1'b0;
    modem_a = '{1'b1, 1'b1, 1'b1, 1'b1};
    modem_b = '{1'b1, 1'b1, 1'b1, 1'b1};
    fails = 0;
    checks_done = 0;
    repeat (4) @(posedge ref_clk);
    test_reset;
    @(posedge ref_clk);
    #5;
    srst = 1'b0;
    repeat (4) @(posedge ref_clk);
    test_modem;
    test_serial;
    test_errors;
    test_mid_reset;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    give_verdict;
  end
endmodule : dual_serial_port_tb
